// *** shared/rcg_pkg.sv ***
package rcg_pkg;
	// ---------------------------------------------
	// Widths, sizes and clock rate
	// ---------------------------------------------
	localparam int PAT_BITS = 1024;
	localparam int LEN_W = 10;
	localparam int DIV_W = 4;
	localparam int SAMPLE_W = 16;
	localparam int ACC_W = 32;
	localparam int NCH = 2;
	localparam int FIFO_DEPTH = 16;
	localparam int CLK_HZ = 20_000_000;
	localparam int PER_W = LEN_W + DIV_W + 1;
	// ---------------------------------------------
	// Reset values, position step and half-point addend
	// ---------------------------------------------
	localparam logic [DIV_W-1:0] DIV_RST = 4'h0;
	localparam logic [LEN_W-1:0] POS_RST = 10'h000;
	localparam logic [LEN_W-1:0] POS_STEP = 10'h001;
	localparam logic [LEN_W:0] HALF_ADD = 11'h002;
	localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
	// Negative pin idles high so the pair is never equal, not even out of reset
	localparam logic CAR_N_RST = 1'b1;
endpackage

// *** shared/rcg_stream_if.sv ***
`timescale 1ns/100ps
interface rcg_stream_if #(parameter int W = 16);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport fifo_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// *** src/rcg_fifo.sv ***
`timescale 1ns/100ps
module rcg_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic nrst,
	rcg_stream_if.fifo_side bus
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic ov;
		logic [W-1:0] od;
	} rcg_fifo_s;
	rcg_fifo_s st_r, st_nxt;
	logic push, fill, take;
	// ---------------------------------------------
	// Storage plus one registered output stage
	// ---------------------------------------------
	assign bus.in_ready = (st_r.cnt != (AW+1)'(DEPTH));
	assign bus.out_valid = st_r.ov;
	assign bus.out_data = st_r.od;
	always_comb begin
		st_nxt = st_r;
		push = bus.in_valid && bus.in_ready;
		take = st_r.ov && bus.out_ready;
		fill = (st_r.cnt != '0) && (!st_r.ov || take);
		if (push) begin
			st_nxt.mem[st_r.wp] = bus.in_data;
			st_nxt.wp = st_r.wp + AW'(1);
		end
		if (fill) begin
			st_nxt.od = st_r.mem[st_r.rp];
			st_nxt.rp = st_r.rp + AW'(1);
			st_nxt.ov = 1'b1;
		end else if (take) begin
			st_nxt.ov = 1'b0;
		end
		st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(fill);
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// *** src/rcg_carrier_gen.sv ***
// Functional notes
// (RULE_01) Pattern store of 1024 bits holds one full carrier cycle.
// (RULE_02) Pattern bit drives positive pin, its complement the negative pin.
// (RULE_03) Ten-bit length field selects 1 to 1024 pattern bits per cycle.
// (RULE_04) Four-bit divider field divides master clock by 1 to 16.
// (RULE_05) Carrier period is clock period times divide ratio times pattern length.
// (RULE_06) Each filter channel has its own demodulator and integrator state.
// (RULE_07) Samples in the negative carrier half are sign inverted.
// (RULE_08) Integrator sums rectified samples over each carrier half cycle.
// (RULE_09) Divide ratio equals divider field value plus one.
// (RULE_10) Pattern circulates without gaps, wrapping after the programmed length.
`timescale 1ns/100ps
module rcg_carrier_gen
	import rcg_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic gen_enable,
	input wire logic [LEN_W-1:0] pattern_length_field,
	input wire logic [DIV_W-1:0] carrier_clock_divider_field,
	input wire logic pat_wr_en,
	input wire logic [LEN_W-1:0] pat_wr_addr,
	input wire logic pat_wr_bit,
	output logic carrier_out_p,
	output logic carrier_out_n,
	output logic carrier_neg_half,
	input wire logic [NCH-1:0] sample_valid,
	input wire logic [NCH-1:0][SAMPLE_W-1:0] sample_data,
	output logic [NCH-1:0] sample_ready,
	output logic [NCH-1:0] result_valid,
	output logic [NCH-1:0][ACC_W-1:0] result_data,
	input wire logic [NCH-1:0] result_ready,
	output logic [NCH-1:0] result_overrun
);
	typedef struct packed {
		logic [PAT_BITS-1:0] pattern;
		logic [DIV_W-1:0] div_cnt;
		logic [LEN_W-1:0] pos;
		logic car_p;
		logic car_n;
		logic neg;
		logic [NCH-1:0][ACC_W-1:0] acc;
		logic [NCH-1:0][ACC_W-1:0] res;
		logic [NCH-1:0] res_v;
		logic [NCH-1:0] ovr;
	} rcg_state_s;
	rcg_state_s st_r, st_nxt;
	localparam rcg_state_s ST_RST = '{car_n: CAR_N_RST, default: '0};
	logic tick, boundary;
	logic [LEN_W-1:0] pos_next, half_idx;
	logic [NCH-1:0] consume;
	logic [NCH-1:0][SAMPLE_W-1:0] fifo_data;
	logic [NCH-1:0] fifo_valid;

	function automatic logic is_neg(input logic [LEN_W-1:0] p, input logic [LEN_W-1:0] h);
		is_neg = (p >= h);
	endfunction

	function automatic logic [ACC_W-1:0] rectify(input logic [SAMPLE_W-1:0] x, input logic neg);
		logic [ACC_W-1:0] ext;
		ext = ACC_W'(signed'(x));
		rectify = neg ? (ACC_W'(0) - ext) : ext;
	endfunction

	// ---------------------------------------------
	// Per-channel sample FIFOs
	// ---------------------------------------------
	// (RULE_06) independent channel paths
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		rcg_stream_if #(.W(SAMPLE_W)) sif ();
		assign sif.in_valid = sample_valid[c];
		assign sif.in_data = sample_data[c];
		assign sample_ready[c] = sif.in_ready;
		// Stall the drain while a result waits, so back-pressure reaches the source
		assign sif.out_ready = !st_r.res_v[c] || result_ready[c];
		assign fifo_valid[c] = sif.out_valid;
		assign fifo_data[c] = sif.out_data;
		assign consume[c] = sif.out_valid && sif.out_ready;
		rcg_fifo #(.W(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
			.clk(clk),
			.nrst(nrst),
			.bus(sif.fifo_side)
		);
	end

	// ---------------------------------------------
	// Pattern timing
	// ---------------------------------------------
	// (RULE_04) divided shift tick
	// (RULE_09) ratio is field plus one
	assign tick = gen_enable && (st_r.div_cnt == carrier_clock_divider_field);
	// (RULE_03) length is field plus one
	// (RULE_10) gapless wrap
	// (RULE_05) period is ratio times length
	assign pos_next = (st_r.pos >= pattern_length_field) ? POS_RST : st_r.pos + POS_STEP;
	assign half_idx = LEN_W'(({1'b0, pattern_length_field} + HALF_ADD) >> 1);
	assign boundary = tick && (pos_next == POS_RST || pos_next == half_idx);

	always_comb begin
		logic [ACC_W-1:0] sum;
		sum = ACC_RST;
		st_nxt = st_r;
		// (RULE_01) pattern load
		if (pat_wr_en) begin
			st_nxt.pattern[pat_wr_addr] = pat_wr_bit;
		end
		if (!gen_enable) begin
			st_nxt.div_cnt = DIV_RST;
		end else if (tick) begin
			st_nxt.div_cnt = DIV_RST;
			st_nxt.pos = pos_next;
		end else begin
			st_nxt.div_cnt = st_r.div_cnt + DIV_W'(1);
		end
		// (RULE_02) differential pin pair from flops
		st_nxt.car_p = st_r.pattern[st_nxt.pos];
		st_nxt.car_n = !st_r.pattern[st_nxt.pos];
		st_nxt.neg = is_neg(st_nxt.pos, half_idx);
		for (int c = 0; c < NCH; c++) begin
			st_nxt.ovr[c] = 1'b0;
			if (st_r.res_v[c] && result_ready[c]) begin
				st_nxt.res_v[c] = 1'b0;
			end
			// (RULE_07) carrier-synchronous rectify
			sum = st_r.acc[c] + (consume[c] ? rectify(fifo_data[c], st_r.neg) : ACC_RST);
			// (RULE_08) half-cycle integration
			if (boundary) begin
				st_nxt.acc[c] = ACC_RST;
				// A full result slot means software is too slow; the sum is dropped
				if (st_nxt.res_v[c]) begin
					st_nxt.ovr[c] = 1'b1;
				end else begin
					st_nxt.res[c] = sum;
					st_nxt.res_v[c] = 1'b1;
				end
			end else begin
				st_nxt.acc[c] = sum;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign carrier_out_p = st_r.car_p;
	assign carrier_out_n = st_r.car_n;
	assign carrier_neg_half = st_r.neg;
	assign result_valid = st_r.res_v;
	assign result_data = st_r.res;
	assign result_overrun = st_r.ovr;

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic [DIV_W:0] gap_r;
	logic [PER_W-1:0] per_r;
	logic cfg_stable_r;
	logic seen_wrap_r;
	logic div_seen_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gap_r <= '0;
			per_r <= '0;
			cfg_stable_r <= 1'b0;
			seen_wrap_r <= 1'b0;
			div_seen_r <= 1'b0;
		end else begin
			// Spacing is only judged between two ticks under one divider setting
			if (tick) begin
				div_seen_r <= 1'b1;
			end else if (!gen_enable || $changed(carrier_clock_divider_field)) begin
				div_seen_r <= 1'b0;
			end
			gap_r <= tick ? '0 : gap_r + (DIV_W+1)'(1);
			per_r <= (tick && pos_next == POS_RST) ? '0 : per_r + PER_W'(1);
			cfg_stable_r <= gen_enable && !pat_wr_en && $stable(pattern_length_field)
				&& $stable(carrier_clock_divider_field) && (cfg_stable_r || !seen_wrap_r);
			if (!gen_enable || $changed(pattern_length_field) || $changed(carrier_clock_divider_field)) begin
				seen_wrap_r <= 1'b0;
			end else if (tick && pos_next == POS_RST) begin
				seen_wrap_r <= 1'b1;
			end
		end
	end

	a_pins_complement: assert property (carrier_out_n == !carrier_out_p) // RULE_02
		else $error("carrier pins not complementary");
	a_div_spacing: assert property (tick && div_seen_r && $stable(carrier_clock_divider_field) // RULE_09
		|-> gap_r == (DIV_W+1)'(carrier_clock_divider_field))
		else $error("divided tick spacing wrong");
	a_pos_wrap: assert property (tick && st_r.pos == pattern_length_field |=> st_r.pos == POS_RST) // RULE_10
		else $error("pattern did not wrap");
	a_pos_step: assert property (tick && st_r.pos < pattern_length_field // RULE_03
		|=> st_r.pos == $past(st_r.pos) + POS_STEP)
		else $error("pattern position did not advance");
	a_out_bit: assert property (!$past(pat_wr_en) |-> carrier_out_p == st_r.pattern[st_r.pos]) // RULE_01
		else $error("pin does not follow pattern bit");
	a_period_len: assert property (tick && pos_next == POS_RST && seen_wrap_r && cfg_stable_r // RULE_05
		|-> 32'(per_r) + 1 == (32'(carrier_clock_divider_field) + 1) * (32'(pattern_length_field) + 1))
		else $error("carrier period mismatch");
	a_demod_sign: assert property (consume[0] && !boundary // RULE_07
		|=> st_r.acc[0] == ($past(st_r.neg) ? $past(st_r.acc[0]) - ACC_W'(signed'($past(fifo_data[0])))
		: $past(st_r.acc[0]) + ACC_W'(signed'($past(fifo_data[0])))))
		else $error("rectified sample not accumulated");
	a_half_result: assert property (boundary && !st_r.res_v[1] // RULE_08
		|=> result_valid[1] && st_r.acc[1] == ACC_RST)
		else $error("half-cycle result not produced");
	a_chan_indep: assert property (consume[0] && !consume[1] && !boundary // RULE_06
		|=> st_r.acc[1] == $past(st_r.acc[1]))
		else $error("channel state coupled");
endmodule

// *** tb/rcg_coil_model.sv ***
`timescale 1ns/100ps
// ----------------------------
// Coil fed through pin impedance
// ----------------------------
module rcg_coil_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic pin_p,
	input wire logic pin_n,
	output logic signed [15:0] level,
	output logic fault
);
	logic armed_r;
	// Leaky sum stands in for the low-pass; equal pins would short the coil drive
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			level <= 16'sh0000;
			fault <= 1'b0;
			armed_r <= 1'b0;
		end else begin
			armed_r <= 1'b1;
			level <= level + (pin_p ? 16'sh0001 : -16'sh0001) - (level >>> 4);
			if (armed_r && pin_p === pin_n)
				fault <= 1'b1;
		end
	end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	import rcg_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic gen_en = 1'b0;
	logic [LEN_W-1:0] len_f = 10'h000;
	logic [DIV_W-1:0] div_f = 4'h0;
	logic wr_en = 1'b0;
	logic [LEN_W-1:0] wr_addr = 10'h000;
	logic wr_bit = 1'b0;
	logic out_p, out_n, neg_half, fault;
	logic [NCH-1:0] s_valid = 2'h0;
	logic [NCH-1:0][SAMPLE_W-1:0] s_data = '0;
	logic [NCH-1:0] s_ready, r_valid, r_ovr;
	logic [NCH-1:0][ACC_W-1:0] r_data;
	logic [NCH-1:0] r_ready = 2'h3;
	logic signed [15:0] coil;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;

	always #25 clk = ~clk;

	rcg_carrier_gen dut (.clk(clk), .nrst(nrst), .gen_enable(gen_en), .pattern_length_field(len_f),
		.carrier_clock_divider_field(div_f), .pat_wr_en(wr_en), .pat_wr_addr(wr_addr), .pat_wr_bit(wr_bit),
		.carrier_out_p(out_p), .carrier_out_n(out_n), .carrier_neg_half(neg_half), .sample_valid(s_valid),
		.sample_data(s_data), .sample_ready(s_ready), .result_valid(r_valid), .result_data(r_data),
		.result_ready(r_ready), .result_overrun(r_ovr));
	rcg_coil_model coil_i (.clk(clk), .nrst(nrst), .pin_p(out_p), .pin_n(out_n), .level(coil), .fault(fault));

	// A hung wait must still reach the verdict
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	// ----------------------------
	// Helpers
	// ----------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask

	task end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task rise(output int n);
		logic p;
		p = out_p;
		for (n = 1; n < 3000 && !(out_p === 1'b1 && p === 1'b0); n++) begin
			p = out_p;
			@(negedge clk);
		end
	endtask

	// ----------------------------
	// Scenarios
	// ----------------------------
	task t_period(input logic [3:0] d, input logic [9:0] l);
		int n;
		div_f = d;
		len_f = l;
		rise(n);
		rise(n);
		rise(n);
		check(n - 1, (int'(d) + 1) * (int'(l) + 1), "period");
		check(out_n, !out_p, "pin pair");
		$display("done: period %0d x %0d", int'(d) + 1, int'(l) + 1);
	endtask

	task t_demod(input logic neg);
		int k;
		for (k = 0; k < 200 && neg_half === neg; k++) @(negedge clk);
		for (k = 0; k < 200 && neg_half !== neg; k++) @(negedge clk);
		repeat (8) @(negedge clk);
		s_data[0] = 16'h0123;
		s_data[1] = 16'h8000;
		s_valid = 2'h3;
		@(negedge clk);
		s_valid = 2'h0;
		for (k = 0; k < 200 && r_valid[0] !== 1'b1; k++) @(negedge clk);
		check(r_data[0], neg ? 32'hFFFF_FEDD : 32'h0000_0123, "ch0 sum");
		check(r_data[1], neg ? 32'h0000_8000 : 32'hFFFF_8000, "ch1 sum");
		$display("done: demod %0d", neg);
	endtask

	task t_stall;
		int k;
		int n;
		r_ready = 2'h0;
		for (k = 0; k < 200 && r_valid[0] !== 1'b1; k++) @(negedge clk);
		s_valid = 2'h1;
		for (n = 0; n < 40 && s_ready[0] === 1'b1; n++) @(negedge clk);
		s_valid = 2'h0;
		check(n, FIFO_DEPTH + 1, "fifo fill");
		for (k = 0; k < 200 && r_ovr[0] !== 1'b1; k++) @(negedge clk);
		check(r_ovr[0], 1'b1, "overrun");
		r_ready = 2'h3;
		repeat (100) @(negedge clk);
		check(s_ready[0], 1'b1, "drained");
		$display("done: stall");
	endtask

	initial begin
		int n;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		check(out_n, 1'b1, "idle pins");
		wr_bit = 1'b1;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		gen_en = 1'b1;
		t_period(4'h3, 10'h003);
		t_period(4'hF, 10'h002);
		t_period(4'h0, 10'h001);
		t_period(4'h0, 10'h3FF);
		// Mostly zero pattern must pull the filtered coil level below midscale
		check(coil < 16'sh0000, 1'b1, "coil level");
		len_f = 10'h03F;
		t_demod(1'b1);
		t_demod(1'b0);
		t_stall();
		// Stop right on the pattern's only one, so the held pin level is known
		rise(n);
		gen_en = 1'b0;
		repeat (30) @(negedge clk);
		check(out_p, 1'b1, "frozen");
		check(fault, 1'b0, "coil drive");
		end_sim();
	end
endmodule
